// ### design/dwf_pkg.sv
package dwf_pkg;
  // Parameter numbers of the readable monitor values
  localparam int unsigned PARAM_BRIDGE_TEMP   = 1368;
  localparam int unsigned PARAM_MOTOR_TEMP    = 1373;
  localparam int unsigned PARAM_AMBIENT_TEMP  = 1378;
  localparam int unsigned PARAM_TOTAL_POWERED = 1482;
  localparam int unsigned PARAM_POWER_DOWNS   = 1484;
  localparam int unsigned PARAM_CUR_ENABLED   = 1487;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ETI_TICK_NS   = 1_000_000_000;
  localparam int unsigned TICK_CYC_DEF  = ETI_TICK_NS / CLK_PERIOD_NS;

  // Warning numbering
  localparam int unsigned WARN_COUNT = 18;
  localparam logic [4:0]  WARN_NONE  = 5'h00;

  // Within 10 % of a maximum: value * 10 >= max * 9
  localparam logic [19:0] NEAR_NUM = 20'h0_0009;
  localparam logic [19:0] NEAR_DEN = 20'h0_000A;

  // Backup supply window in millivolts (18 V and 32 V)
  localparam logic [15:0] BACKUP_MIN_MV = 16'h4650;
  localparam logic [15:0] BACKUP_MAX_MV = 16'h7D00;

  // Current and velocity scale in percent
  localparam logic [6:0]  SCALE_FULL_PCT = 7'h64;

  // Reset values
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;
  localparam logic [15:0] TEMP_RST = 16'h0000;
  localparam logic [17:0] WARN_RST = 18'h0_0000;

  typedef enum logic [4:0] {
    DISP_BLANK   = 5'b00001,
    DISP_READY   = 5'b00010,
    DISP_ENABLED = 5'b00100,
    DISP_WARNING = 5'b01000,
    DISP_FAULT   = 5'b10000
  } dwf_disp_t;
endpackage

// ### design/dwf_monitor.sv
`timescale 1ns/100ps
module dwf_monitor
  import dwf_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic        i_ref_clk,          // Drive clock
  input  wire logic        i_sys_rst,          // Sync reset, high
  input  wire logic        i_fault_active,     // A fault is present
  input  wire logic [4:0]  i_fault_num,        // Number of the fault
  input  wire logic        i_brake_fitted,     // Motor brake present
  input  wire logic        i_logic_ok,         // Logic voltage applied
  input  wire logic        i_hv_ready,         // High power ready
  input  wire logic        i_soft_start,       // Soft start running
  input  wire logic        i_hw_enable,        // Hardware enable input
  input  wire logic        i_enable_req,       // Enable request pulse
  input  wire logic        i_disable_req,      // Disable request pulse
  input  wire logic        i_power_down,       // Power-down event pulse
  input  wire logic [15:0] i_bridge_temp,      // Bridge temperature
  input  wire logic [15:0] i_bridge_temp_max,  // Bridge maximum
  input  wire logic [15:0] i_motor_temp,       // Winding temperature
  input  wire logic [15:0] i_motor_temp_max,   // Winding maximum
  input  wire logic [15:0] i_ambient_temp,     // Control card temperature
  input  wire logic [15:0] i_ambient_temp_max, // Ambient maximum
  input  wire logic [15:0] i_regen_power,      // Filtered regen power
  input  wire logic [15:0] i_regen_rating,     // Continuous regen rating
  input  wire logic [15:0] i_pos_error,        // Position error magnitude
  input  wire logic [15:0] i_pos_err_limit,    // Tracking threshold
  input  wire logic        i_pos_mode,         // Position control selected
  input  wire logic        i_limit_cw,         // Clockwise limit active
  input  wire logic        i_limit_ccw,        // Counter-clockwise limit
  input  wire logic [15:0] i_backup_mv,        // Backup supply, mV
  input  wire logic        i_manual_mode,      // Manual operation
  input  wire logic [6:0]  i_manual_pct,       // Manual scale, percent
  input  wire logic [2:0]  i_thermal_limiting, // Bridge, motor, ambient
  input  wire logic        i_version_mismatch, // Firmware vs fieldbus
  input  wire logic [1:0]  i_model_warn,       // Application warnings
  input  wire logic [15:0] i_current_demand,   // Signed demand pre-limit
  input  wire logic [15:0] i_i2t_limit,        // I2t current limit
  input  wire logic [31:0] i_it_integral,      // Integrated demand
  input  wire logic [31:0] i_it_max,           // Max current-time product
  output logic             o_amp_power_on,     // Amplifier power allowed
  output logic             o_brake_engage,     // Engage motor brake
  output logic             o_drive_enabled,    // Drive enabled
  output logic             o_engage_blocked,   // Engage refused
  output logic             o_inhibit_cw,       // No clockwise motion
  output logic             o_inhibit_ccw,      // No counter-clockwise
  output logic             o_current_limited,  // Current is limited
  output logic [6:0]       o_current_pct,      // Current limit scale
  output logic [6:0]       o_velocity_pct,     // Velocity limit scale
  output dwf_disp_t        o_disp_mode,        // Display symbol
  output logic [4:0]       o_disp_num,         // Number after U or F
  output logic             o_disp_dot,         // Current limit dot
  output logic [17:0]      o_warnings,         // Warning bits, U1 at 0
  output logic [15:0]      o_bridge_temp,      // Readable bridge temp
  output logic [15:0]      o_motor_temp,       // Readable motor temp
  output logic [15:0]      o_ambient_temp,     // Readable ambient temp
  output logic [31:0]      o_total_powered,    // Powered seconds
  output logic [31:0]      o_powered_since_on, // Seconds since power-up
  output logic [31:0]      o_power_downs,      // Power-down count
  output logic [31:0]      o_enabled_total,    // Enabled seconds total
  output logic [31:0]      o_enabled_since_on, // Enabled since power-up
  output logic [31:0]      o_current_enabled   // Enabled since enable
);

  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic        tick;
  logic        refused_reg;
  logic [17:0] warn;
  logic [4:0]  warn_num;
  logic        near_motor;
  logic        near_bridge;
  logic        near_ambient;
  logic        near_regen;
  logic [15:0] demand_abs;
  logic        preconds_ok;
  logic        enable_ok;
  logic        enable_refused;
  logic        enabled_next;
  logic        dot_next;
  logic        limited_next;
  dwf_disp_t   disp_next;
  logic [4:0]  num_next;
  logic [6:0]  scale_next;
  logic        enable_rise;
  logic        enabled_tick;

  // Widened to 20 bits so that max * 9 cannot overflow the 16-bit reading
  function automatic logic near_max(input logic [15:0] v, input logic [15:0] m);
    near_max = ({4'h0, v} * NEAR_DEN) >= ({4'h0, m} * NEAR_NUM);
  endfunction

  assign near_motor   = near_max(i_motor_temp, i_motor_temp_max);
  assign near_bridge  = near_max(i_bridge_temp, i_bridge_temp_max);
  assign near_ambient = near_max(i_ambient_temp, i_ambient_temp_max);
  assign near_regen   = near_max(i_regen_power, i_regen_rating);
  assign demand_abs   = i_current_demand[15] ? (16'h0000 - i_current_demand)
                                             : i_current_demand;

  assign warn[0]  = i_soft_start & ~i_hv_ready;
  assign warn[1]  = near_motor;
  assign warn[2]  = near_bridge;
  assign warn[3]  = near_regen;
  assign warn[4]  = i_pos_mode & (i_pos_error > i_pos_err_limit);
  assign warn[5]  = i_limit_cw | i_limit_ccw;
  assign warn[6]  = (i_backup_mv < BACKUP_MIN_MV)
                  | (i_backup_mv > BACKUP_MAX_MV);
  assign warn[7]  = i_manual_mode;
  assign warn[8]  = refused_reg;
  assign warn[9]  = i_thermal_limiting[0];
  assign warn[10] = i_thermal_limiting[1];
  assign warn[11] = i_thermal_limiting[2];
  assign warn[12] = near_ambient;
  assign warn[13] = i_version_mismatch;
  assign warn[14] = i_model_warn[0];
  assign warn[15] = i_model_warn[1];
  assign warn[16] = o_drive_enabled & (demand_abs >= i_i2t_limit);
  assign warn[17] = i_it_integral > i_it_max;

  // Lowest number wins: scan from the top so the last hit is the smallest
  always_comb begin
    warn_num = WARN_NONE;
    for (int i = WARN_COUNT - 1; i >= 0; i--) begin
      if (warn[i]) begin
        warn_num = 5'(i + 1);
      end
    end
  end

  // Enable needs hardware enable, high power, no soft start, no mismatch
  assign preconds_ok    = i_logic_ok & i_hv_ready & i_hw_enable
                        & ~warn[0] & ~i_version_mismatch;
  assign enable_ok      = i_enable_req & ~i_fault_active & preconds_ok;
  assign enable_refused = i_enable_req & ~i_fault_active & ~preconds_ok;
  assign enabled_next   = i_fault_active      ? 1'b0 :
                          i_disable_req       ? 1'b0 :
                          ~preconds_ok        ? 1'b0 :
                          enable_ok           ? 1'b1 : o_drive_enabled;

  // Manual mode, foldback and I2t/IT all light the dot
  assign dot_next     = (|i_thermal_limiting) | i_manual_mode
                      | warn[16] | warn[17];
  assign limited_next = dot_next | near_motor | near_bridge
                      | near_ambient;

  assign disp_next = i_fault_active        ? DISP_FAULT   :
                     (warn_num != WARN_NONE) ? DISP_WARNING :
                     o_drive_enabled       ? DISP_ENABLED :
                     (i_logic_ok & i_hv_ready) ? DISP_READY : DISP_BLANK;
  assign num_next  = i_fault_active ? i_fault_num : warn_num;

  // Tick period sets the unit of every elapsed-time counter
  assign tick          = (tick_cnt_reg == TICK_CYC - 1);
  assign tick_cnt_next = tick ? CNT_RST : tick_cnt_reg + 32'h0000_0001;
  assign enable_rise   = enabled_next & ~o_drive_enabled;
  assign enabled_tick  = tick & o_drive_enabled;
  assign scale_next    = i_manual_mode ? i_manual_pct : SCALE_FULL_PCT;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      refused_reg <= 1'b0;
    end else if (enable_refused) begin
      refused_reg <= 1'b1;
    end else if (o_drive_enabled) begin
      refused_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_amp_power_on    <= 1'b0;
      o_brake_engage    <= 1'b0;
      o_drive_enabled   <= 1'b0;
      o_engage_blocked  <= 1'b0;
    end else begin
      o_amp_power_on    <= ~i_fault_active & i_hv_ready;
      o_brake_engage    <= i_fault_active & i_brake_fitted;
      o_drive_enabled   <= enabled_next;
      o_engage_blocked  <= ~preconds_ok;
    end
  end

  // Only the blocked direction stops, so the axis can still leave a switch
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_inhibit_cw      <= 1'b0;
      o_inhibit_ccw     <= 1'b0;
    end else begin
      o_inhibit_cw      <= i_limit_cw;
      o_inhibit_ccw     <= i_limit_ccw;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_current_limited <= 1'b0;
      o_current_pct     <= SCALE_FULL_PCT;
      o_velocity_pct    <= SCALE_FULL_PCT;
    end else begin
      o_current_limited <= limited_next;
      o_current_pct     <= scale_next;
      o_velocity_pct    <= scale_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_disp_mode       <= DISP_BLANK;
      o_disp_num        <= WARN_NONE;
      o_disp_dot        <= 1'b0;
      o_warnings        <= WARN_RST;
    end else begin
      o_disp_mode       <= disp_next;
      o_disp_num        <= num_next;
      o_disp_dot        <= dot_next;
      o_warnings        <= warn;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_bridge_temp  <= TEMP_RST;
      o_motor_temp   <= TEMP_RST;
      o_ambient_temp <= TEMP_RST;
    end else begin
      o_bridge_temp  <= i_bridge_temp;
      o_motor_temp   <= i_motor_temp;
      o_ambient_temp <= i_ambient_temp;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tick_cnt_reg <= CNT_RST;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Totals restart at reset; preloading from non-volatile storage is outside
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_total_powered    <= CNT_RST;
      o_powered_since_on <= CNT_RST;
    end else if (tick) begin
      o_total_powered    <= o_total_powered + 32'h0000_0001;
      o_powered_since_on <= o_powered_since_on + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_power_downs <= CNT_RST;
    end else if (i_power_down) begin
      o_power_downs <= o_power_downs + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_enabled_total    <= CNT_RST;
      o_enabled_since_on <= CNT_RST;
    end else if (enabled_tick) begin
      o_enabled_total    <= o_enabled_total + 32'h0000_0001;
      o_enabled_since_on <= o_enabled_since_on + 32'h0000_0001;
    end
  end

  // A fresh enable restarts the per-enable time
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_current_enabled <= CNT_RST;
    end else if (enable_rise) begin
      o_current_enabled <= CNT_RST;
    end else if (enabled_tick) begin
      o_current_enabled <= o_current_enabled + 32'h0000_0001;
    end
  end

endmodule

// ### sim/dwf_monitor_checker.sv
`timescale 1ns/100ps
module dwf_monitor_checker
  import dwf_pkg::*;
(
  input wire logic        i_ref_clk, i_sys_rst, i_fault_active, i_brake_fitted,
  input wire logic        i_soft_start, i_hv_ready, i_enable_req, i_hw_enable,
  input wire logic        i_manual_mode, i_limit_cw, o_amp_power_on, o_brake_engage,
  input wire logic        o_disp_dot, o_drive_enabled, o_inhibit_cw,
  input wire logic [4:0]  i_fault_num, o_disp_num,
  input wire logic [2:0]  i_thermal_limiting,
  input wire logic [6:0]  i_manual_pct, o_current_pct, o_velocity_pct,
  input wire logic [17:0] o_warnings,
  input wire dwf_disp_t   o_disp_mode
);
  // Warnings numbered below the one on show must all be quiet
  logic [17:0] lower_mask;
  assign lower_mask = (18'h0_0001 << (o_disp_num - 5'h01)) - 18'h0_0001;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_fault_amp_off: assert property (
    i_fault_active |=> !o_amp_power_on && !o_drive_enabled) else $error("amplifier on in fault");
  chk_fault_brake: assert property (
    i_fault_active && i_brake_fitted |=> o_brake_engage) else $error("brake not engaged");
  chk_fault_code: assert property (
    i_fault_active |=> o_disp_mode == DISP_FAULT && o_disp_num == $past(i_fault_num))
    else $error("fault code not shown");
  chk_warn_shown: assert property (
    !i_fault_active && i_limit_cw |=> o_disp_mode == DISP_WARNING) else $error("warning hidden");
  chk_dot_thermal: assert property (
    i_thermal_limiting != 3'h0 |=> o_disp_dot && o_warnings[11:9] == $past(i_thermal_limiting))
    else $error("thermal limit not flagged");
  chk_soft_start: assert property (
    i_soft_start && !i_hv_ready |=> o_warnings[0] && !o_drive_enabled)
    else $error("soft start warning missing");
  chk_limit_inhibit: assert property (
    i_limit_cw |=> o_inhibit_cw && o_warnings[5]) else $error("limit switch not inhibiting");
  chk_manual_scale: assert property (
    1'b1 |=> o_velocity_pct == ($past(i_manual_mode) ? $past(i_manual_pct) : SCALE_FULL_PCT)
    && o_current_pct == o_velocity_pct) else $error("manual scale wrong");
  chk_refused_enable: assert property (
    i_enable_req && !i_fault_active && !i_hw_enable |=> ##1 o_warnings[8] && !o_drive_enabled)
    else $error("refused enable not latched");
  chk_lowest_warn: assert property (
    o_disp_mode == DISP_WARNING |-> o_warnings[o_disp_num - 5'h01]
    && (o_warnings & lower_mask) == 18'h0_0000) else $error("shown warning not lowest");
endmodule

// ### sim/dwf_sensor_model.sv
`timescale 1ns/100ps
module dwf_sensor_model (
  input  wire logic [2:0]  i_hot,        // Bridge, motor, ambient near max
  input  wire logic        i_regen_hi,   // Regen near rating
  input  wire logic [1:0]  i_backup_sel, // 0 nominal, 1 low, 2 high
  output logic      [15:0] o_bridge,     // Bridge reading
  output logic      [15:0] o_motor,      // Winding reading
  output logic      [15:0] o_amb,        // Ambient reading
  output logic      [15:0] o_regen,      // Regen power
  output logic      [15:0] o_max,        // Every maximum and rating
  output logic      [15:0] o_backup_mv   // Backup supply
);
  // Near readings sit on the 90 % point and safe ones one count below it, so any slip shows
  localparam logic [15:0] NEAR_V = 16'h00B4;
  localparam logic [15:0] SAFE_V = 16'h00B3;
  assign o_max = 16'h00C8;
  assign o_bridge = i_hot[0] ? NEAR_V : SAFE_V;
  assign o_motor = i_hot[1] ? NEAR_V : SAFE_V;
  assign o_amb = i_hot[2] ? NEAR_V : SAFE_V;
  assign o_regen = i_regen_hi ? NEAR_V : SAFE_V;
  assign o_backup_mv = (i_backup_sel == 2'h1) ? 16'h464F :
                       (i_backup_sel == 2'h2) ? 16'h7D01 : 16'h5DC0;
endmodule

// ### sim/dwf_monitor_tb_top.sv
`timescale 1ns/100ps
module dwf_monitor_tb_top;
  import dwf_pkg::*;
  localparam logic [17:0] LIM_MASK = 18'h2_1E86;
  logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_fault_active = 1'b0, i_brake_fitted = 1'b0;
  logic        i_logic_ok = 1'b0, i_hv_ready = 1'b0, i_soft_start = 1'b0, i_hw_enable = 1'b0;
  logic        i_enable_req = 1'b0, i_disable_req = 1'b0, i_power_down = 1'b0;
  logic        i_pos_mode = 1'b1, i_limit_cw = 1'b0, i_limit_ccw = 1'b0, i_manual_mode = 1'b0;
  logic        i_version_mismatch = 1'b0, regen_hi = 1'b0;
  logic [1:0]  i_model_warn = 2'h0, backup_sel = 2'h0;
  logic [2:0]  i_thermal_limiting = 3'h0, hot = 3'h0;
  logic [4:0]  i_fault_num = 5'h00, o_disp_num;
  logic [6:0]  i_manual_pct = 7'h32, o_current_pct, o_velocity_pct;
  logic [15:0] i_pos_error = 16'h0000, i_pos_err_limit = 16'h0064;
  logic [15:0] i_current_demand = 16'h0000, i_i2t_limit = 16'h0100;
  logic [31:0] i_it_integral = 32'h0000_1000, i_it_max = 32'h0000_1000;
  logic [15:0] i_bridge_temp, i_motor_temp, i_ambient_temp, i_regen_power, i_backup_mv, mx;
  logic [15:0] o_bridge_temp, o_motor_temp, o_ambient_temp;
  logic        o_amp_power_on, o_brake_engage, o_drive_enabled, o_engage_blocked;
  logic        o_inhibit_cw, o_inhibit_ccw, o_current_limited, o_disp_dot;
  dwf_disp_t   o_disp_mode;
  logic [17:0] o_warnings;
  logic [31:0] o_total_powered, o_powered_since_on, o_power_downs, o_enabled_total;
  logic [31:0] o_enabled_since_on, o_current_enabled, a, b, c, d, e;
  int          bad_count = 0, check_count = 0, cyc = 0;
  wire  [15:0] i_bridge_temp_max = mx, i_motor_temp_max = mx, i_ambient_temp_max = mx;
  wire  [15:0] i_regen_rating = mx;
  dwf_sensor_model dwf_sensor_model_i (.i_hot(hot), .i_regen_hi(regen_hi),
    .i_backup_sel(backup_sel), .o_bridge(i_bridge_temp), .o_motor(i_motor_temp),
    .o_amb(i_ambient_temp), .o_regen(i_regen_power), .o_max(mx), .o_backup_mv(i_backup_mv));
  dwf_monitor #(.TICK_CYC(4)) dwf_monitor_i (.*);
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // One-cycle pulse: 0 enable, 1 disable, 2 power-down
  task automatic pulse(input int s);
    @(posedge i_ref_clk);
    case (s)
      0: i_enable_req <= 1'b1;
      1: i_disable_req <= 1'b1;
      default: i_power_down <= 1'b1;
    endcase
    @(posedge i_ref_clk);
    {i_enable_req, i_disable_req, i_power_down} <= 3'h0;
    #1;
  endtask
  task automatic t_ready();
    @(posedge i_ref_clk);
    {i_logic_ok, i_hv_ready, i_hw_enable} <= 3'h7;
    tick(1);
    check("ready display", o_disp_mode, DISP_READY);
    check("amp power", o_amp_power_on, 1'b1);
    pulse(0);
    tick(1);
    check("enabled display", o_disp_mode, DISP_ENABLED);
  endtask
  task automatic t_counters();
    a = o_total_powered;
    b = o_enabled_total;
    c = o_current_enabled;
    d = o_powered_since_on;
    e = o_enabled_since_on;
    tick(40);
    check("powered since on", o_powered_since_on - d, 32'h0000_000A);
    check("enabled since on", o_enabled_since_on - e, 32'h0000_000A);
    check("motor temp", o_motor_temp, 16'h00B3);
    check("powered time", o_total_powered - a, 32'h0000_000A);
    check("enabled total", o_enabled_total - b, 32'h0000_000A);
    check("current enabled", o_current_enabled - c, 32'h0000_000A);
    check("bridge temp", o_bridge_temp, 16'h00B3);
    check("ambient temp", o_ambient_temp, 16'h00B3);
    a = o_power_downs;
    pulse(2);
    pulse(2);
    tick(1);
    check("power downs", o_power_downs - a, 32'h0000_0002);
  endtask
  task automatic t_i2t();
    @(posedge i_ref_clk);
    i_current_demand <= 16'hFF00;
    tick(2);
    check("i2t warning", o_warnings[16], 1'b1);
    @(posedge i_ref_clk);
    i_current_demand <= 16'hFF01;
    tick(2);
    check("i2t below", o_warnings[16], 1'b0);
  endtask
  task automatic t_fault();
    @(posedge i_ref_clk);
    {i_fault_active, i_brake_fitted, i_limit_cw} <= 3'h7;
    i_fault_num <= 5'h05;
    tick(1);
    check("fault amp", o_amp_power_on, 1'b0);
    check("fault brake", o_brake_engage, 1'b1);
    check("fault over warning", o_disp_mode, DISP_FAULT);
    check("fault number", o_disp_num, 5'h05);
    @(posedge i_ref_clk);
    i_fault_active <= 1'b0;
    tick(1);
    check("warning number", o_disp_num, 5'h06);
    @(posedge i_ref_clk);
    i_limit_cw <= 1'b0;
    tick(1);
    check("back to ready", o_disp_mode, DISP_READY);
  endtask
  task automatic apply(input int k, input logic v);
    case (k)
      0: {i_soft_start, i_hv_ready} <= {v, !v};
      1: hot[1] <= v;
      2: hot[0] <= v;
      3: regen_hi <= v;
      4: i_pos_error <= v ? 16'h0065 : 16'h0064;
      5: i_limit_ccw <= v;
      6: backup_sel <= {1'b0, v};
      7: i_manual_mode <= v;
      9, 10, 11: i_thermal_limiting[k-9] <= v;
      12: hot[2] <= v;
      13: i_version_mismatch <= v;
      14, 15: i_model_warn[k-14] <= v;
      17: i_it_integral <= v ? 32'h0000_1001 : 32'h0000_1000;
      default: ;
    endcase
  endtask
  task automatic t_table();
    for (int k = 0; k < 18; k++) begin
      if (k == 8 || k == 16)
        continue;
      @(posedge i_ref_clk);
      apply(k, 1'b1);
      tick(1);
      check("warn bits", o_warnings, 18'h0_0001 << k);
      check("warn number", o_disp_num, k + 1);
      check("current limit", o_current_limited, LIM_MASK[k]);
      check("engage blocked", o_engage_blocked, k == 0 || k == 13);
      check("inhibit ccw", o_inhibit_ccw, k == 5);
      @(posedge i_ref_clk);
      apply(k, 1'b0);
    end
    @(posedge i_ref_clk);
    apply(3, 1'b1);
    apply(12, 1'b1);
    backup_sel <= 2'h2;
    i_pos_mode <= 1'b0;
    i_pos_error <= 16'h0065;
    tick(1);
    check("mixed warnings", o_warnings, 18'h0_1048);
    check("lowest shown", o_disp_num, 5'h04);
    @(posedge i_ref_clk);
    apply(3, 1'b0);
    apply(12, 1'b0);
    backup_sel <= 2'h0;
  endtask
  task automatic t_refused();
    @(posedge i_ref_clk);
    i_hw_enable <= 1'b0;
    pulse(0);
    tick(1);
    check("refused latch", o_disp_num, 5'h09);
    @(posedge i_ref_clk);
    i_hw_enable <= 1'b1;
    pulse(0);
    check("now enabled", o_drive_enabled, 1'b1);
    tick(2);
    check("latch cleared", o_warnings[8], 1'b0);
    pulse(1);
    check("disabled", o_drive_enabled, 1'b0);
    tick(1);
    check("ready again", o_disp_mode, DISP_READY);
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    #1;
    check("reset scale", o_current_pct, SCALE_FULL_PCT);
    check("reset display", o_disp_mode, DISP_BLANK);
    @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    t_ready();
    t_counters();
    t_i2t();
    t_fault();
    t_table();
    t_refused();
    end_sim();
  end
endmodule
bind dwf_monitor dwf_monitor_checker dwf_monitor_checker_i (.*);
